/* rtl/isp_pkg.sv */
// Shared constants of the inbound socket transfer engine and its controller
package isp_pkg;
	// ==========================================================
	// Link register port
	localparam int ADR_W = 12;
	localparam int DAT_W = 32;
	localparam logic [11:0] OFS_PEND = 12'h008;
	localparam logic [11:0] OFS_INSTR = 12'h00c;
	localparam logic [11:0] OFS_DESC_BASE = 12'h100;
	localparam logic [11:0] OFS_CTL_STAT = 12'h020;
	localparam int WIN_LSB = 8;
	localparam int DESC_IDX_LSB = 5;
	localparam int DESC_WORD_LSB = 2;

	// ==========================================================
	// Descriptor layout, eight 32-bit words per slot
	localparam int DESC_WORDS = 8;
	localparam logic [2:0] W_BUF = 3'h0;
	localparam logic [2:0] W_LEN = 3'h1;
	localparam logic [2:0] W_RDV0 = 3'h2;
	localparam logic [2:0] W_RDV1 = 3'h3;
	localparam logic [2:0] BODY_BASE = 3'h4;
	localparam logic [2:0] BODY_WORDS = 3'h4;

	// ==========================================================
	// Pending entry and instruction fields
	localparam int ENT_EMPTY_BIT = 0;
	localparam int ENT_PAY_BIT = 1;
	localparam int ENT_REF_LSB = 8;
	localparam int INS_OP_LSB = 0;
	localparam int INS_KEEP_BIT = 3;
	localparam int INS_REF_LSB = 8;
	localparam logic [31:0] ENT_EMPTY_VAL = 32'h0000_0001;

	// ==========================================================
	// Opcodes
	localparam logic [2:0] OP_FREE = 3'h0;
	localparam logic [2:0] OP_FLUSH = 3'h1;
	localparam logic [2:0] OP_MOVE = 3'h2;
	localparam logic [2:0] OP_RDV = 3'h4;
	localparam logic [2:0] OP_MOVE_RDV = 3'h6;

	// ==========================================================
	// Controller status fields
	localparam int STAT_EMPTY_BIT = 0;
	localparam int STAT_CNT_LSB = 8;
endpackage

/* rtl/isp_sock_if.sv */
// Register link between socket engine and its controller
`timescale 1ns/10ps
interface isp_sock_if;
	logic req;
	logic we;
	logic [11:0] adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic ack;

	modport sock (
		input req,
		input we,
		input adr,
		input wdat,
		output rdat,
		output ack
	);

	modport ctl (
		output req,
		output we,
		output adr,
		output wdat,
		input rdat,
		input ack
	);
endinterface

/* rtl/isp_sock_end.sv */
// Inbound socket: header engine, payload engine, descriptor store and lists
// What this block and its software do
// RQ1 - Frame takes free descriptor, header copied, queued
// RQ2 - Pending read pops one entry per frame
// RQ3 - Entry carries descriptor reference and payload flag
// RQ4 - Software returns each frame by one instruction
// RQ5 - One instruction disposes payload and releases descriptor
// RQ6 - Opcode 0 consumes nothing, conditionally recycles
// RQ7 - Software fills free-list with opcode 0 after reset
// RQ8 - Opcode 1 flushes oldest payload, recycles
// RQ9 - Opcode 2 moves payload, silently truncates
// RQ10 - Opcode 4 rendezvous only, then recycles
// RQ11 - Opcode 6 moves, truncates, rendezvous, recycles
// RQ12 - Reserved opcodes act as plain release
// RQ13 - Instructions run one at a time in order
// RQ14 - Header quadword one holds buffer address, length
// RQ15 - Any byte alignment, no cache coherence
// RQ16 - Software supplies flushed or uncached buffers
// RQ17 - Zero length discards whole payload
// RQ18 - Software keeps length within frame and space
// RQ19 - Header quadword two holds rendezvous reference
// RQ20 - Opcode 2 ignores rendezvous reference
// RQ21 - Outstanding frames bounded by free-list population
// RQ22 - Pending at offset 08, instruction at 12
// RQ23 - Empty pending read returns flag, no stall
// RQ24 - No free descriptor stalls plug-in headers
`timescale 1ns/10ps

// ==========================================================
// Small flip-flop FIFO
module isp_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic push_i,
	input wire logic [W-1:0] din_i,
	input wire logic pop_i,
	output logic [W-1:0] dout_o,
	output logic empty_o,
	output logic full_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} isp_fifo_s;
	isp_fifo_s q;
	isp_fifo_s d;
	logic do_push;
	logic do_pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("FIFO depth must be a power of two of at least 2");
	end

	assign empty_o = (q.cnt == '0);
	assign full_o = (q.cnt == (AW+1)'(DEPTH));
	assign dout_o = q.mem[q.rd];
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;

	always_comb begin
		d = q;
		if (do_push) begin
			d.mem[q.wr] = din_i;
			d.wr = q.wr + 1'b1;
		end
		if (do_pop) begin
			d.rd = q.rd + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// ==========================================================
// Socket end
module isp_sock_end #(
	parameter int DESC_NUM = 8
) (
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	isp_sock_if.sock lnk,
	input wire logic HDR_VALID_I,
	input wire logic [31:0] HDR_DATA_I,
	input wire logic HDR_LAST_I,
	input wire logic HDR_HAS_PAY_I,
	output logic HDR_READY_O,
	input wire logic PAY_VALID_I,
	input wire logic [7:0] PAY_DATA_I,
	input wire logic PAY_LAST_I,
	output logic PAY_READY_O,
	output logic MEM_WE_O,
	output logic [31:0] MEM_ADR_O,
	output logic [7:0] MEM_DAT_O,
	output logic RDV_VALID_O,
	output logic [63:0] RDV_CTX_O,
	input wire logic RDV_READY_I,
	output logic BUSY_O
);
	localparam int IW = $clog2(DESC_NUM);

	if (DESC_NUM < 2 || DESC_NUM > 8 || (DESC_NUM & (DESC_NUM - 1)) != 0) begin : g_chk
		$error("DESC_NUM must be 2, 4 or 8");
	end

	typedef enum logic [1:0] {H_IDLE, H_BODY} isp_hst_e;
	typedef enum logic [1:0] {P_IDLE, P_MOVE, P_RDV, P_DONE} isp_pst_e;
	typedef struct packed {
		logic [DESC_NUM-1:0][isp_pkg::DESC_WORDS-1:0][31:0] desc;
		isp_hst_e hst;
		logic [IW-1:0] hidx;
		logic [2:0] hcnt;
		isp_pst_e pst;
		logic [IW-1:0] pidx;
		logic [2:0] pop;
		logic pkeep;
		logic [31:0] pcnt;
		logic hdr_ready;
		logic pay_ready;
		logic mem_we;
		logic [31:0] mem_adr;
		logic [7:0] mem_dat;
		logic rdv_valid;
		logic [63:0] rdv_ctx;
		logic busy;
		logic ack;
		logic [31:0] rdat;
	} isp_sock_s;
	isp_sock_s q;
	isp_sock_s d;

	logic free_push, free_pop, free_empty, free_full;
	logic [IW-1:0] free_dout;
	logic pend_push, pend_pop, pend_empty, pend_full;
	logic [31:0] pend_din, pend_dout;
	logic ins_push, ins_pop, ins_empty, ins_full;
	logic [31:0] ins_dout;
	logic in_win;
	logic [IW-1:0] win_idx;
	logic [2:0] win_word;
	logic [2:0] ins_op;
	logic op_pay, op_wr, op_rdv;

	// ==========================================================
	// Lists; depth equals descriptor count so none of the three lists can overflow
	isp_fifo #(.W(IW), .DEPTH(DESC_NUM)) u_free (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I), .push_i(free_push), .din_i(q.pidx),
		.pop_i(free_pop), .dout_o(free_dout), .empty_o(free_empty), .full_o(free_full)
	); // [RQ21]
	isp_fifo #(.W(32), .DEPTH(DESC_NUM)) u_pend (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I), .push_i(pend_push), .din_i(pend_din),
		.pop_i(pend_pop), .dout_o(pend_dout), .empty_o(pend_empty), .full_o(pend_full)
	);
	isp_fifo #(.W(32), .DEPTH(DESC_NUM)) u_ins (
		.clk_i(REF_CLK_I), .arst_n_i(ARST_N_I), .push_i(ins_push), .din_i(lnk.wdat),
		.pop_i(ins_pop), .dout_o(ins_dout), .empty_o(ins_empty), .full_o(ins_full)
	); // [RQ13]

	// ==========================================================
	// Decode
	assign in_win = (lnk.adr[11:isp_pkg::WIN_LSB] ==
		isp_pkg::OFS_DESC_BASE[11:isp_pkg::WIN_LSB]) &&
		({29'h0, lnk.adr[7:5]} < DESC_NUM);
	assign win_idx = lnk.adr[isp_pkg::DESC_IDX_LSB +: IW];
	assign win_word = lnk.adr[isp_pkg::DESC_WORD_LSB +: 3];
	assign ins_op = ins_dout[isp_pkg::INS_OP_LSB +: 3];
	// Reserved codes fall out as plain releases
	assign op_pay = (ins_op == isp_pkg::OP_FLUSH) || (ins_op == isp_pkg::OP_MOVE) ||
		(ins_op == isp_pkg::OP_MOVE_RDV); // [RQ12]
	assign op_wr = (ins_op == isp_pkg::OP_MOVE) || (ins_op == isp_pkg::OP_MOVE_RDV);
	assign op_rdv = (ins_op == isp_pkg::OP_RDV) || (ins_op == isp_pkg::OP_MOVE_RDV);

	always_comb begin
		d = q;
		free_push = 1'b0;
		free_pop = 1'b0;
		pend_push = 1'b0;
		pend_pop = 1'b0;
		pend_din = '0;
		ins_push = 1'b0;
		ins_pop = 1'b0;
		d.ack = 1'b0;
		d.mem_we = 1'b0;

		// ==========================================================
		// Register access, always answered in one cycle
		if (lnk.req && !q.ack) begin
			d.ack = 1'b1;
			d.rdat = '0;
			if (lnk.we) begin
				if (lnk.adr == isp_pkg::OFS_INSTR) begin
					ins_push = !ins_full; // [RQ22] [RQ5]
				end else if (in_win) begin
					d.desc[win_idx][win_word] = lnk.wdat;
				end
			end else if (lnk.adr == isp_pkg::OFS_PEND) begin
				if (pend_empty) begin
					d.rdat = isp_pkg::ENT_EMPTY_VAL; // [RQ23]
				end else begin
					pend_pop = 1'b1; // [RQ2] [RQ22]
					d.rdat = pend_dout;
				end
			end else if (in_win) begin
				d.rdat = q.desc[win_idx][win_word];
			end
		end

		// ==========================================================
		// Header engine
		case (q.hst)
			H_IDLE: begin
				// Without a free descriptor the plug-in simply waits
				if (HDR_VALID_I && !free_empty) begin // [RQ24]
					free_pop = 1'b1; // [RQ1]
					d.hidx = free_dout;
					d.hcnt = '0;
					d.hst = H_BODY;
				end
			end
			H_BODY: begin
				if (HDR_VALID_I) begin
					// Words beyond the body are dropped
					if (q.hcnt < isp_pkg::BODY_WORDS) begin
						d.desc[q.hidx][isp_pkg::BODY_BASE + q.hcnt] = HDR_DATA_I; // [RQ1]
						d.hcnt = q.hcnt + 3'h1;
					end
					if (HDR_LAST_I) begin
						pend_push = 1'b1; // [RQ1]
						pend_din[isp_pkg::ENT_PAY_BIT] = HDR_HAS_PAY_I; // [RQ3]
						pend_din[isp_pkg::ENT_REF_LSB +: IW] = q.hidx; // [RQ3]
						d.hst = H_IDLE;
					end
				end
			end
			default: d.hst = H_IDLE;
		endcase

		// ==========================================================
		// Payload engine, one instruction at a time
		case (q.pst)
			P_IDLE: begin
				if (!ins_empty) begin
					ins_pop = 1'b1; // [RQ13]
					d.pidx = ins_dout[isp_pkg::INS_REF_LSB +: IW];
					d.pop = ins_op;
					d.pkeep = ins_dout[isp_pkg::INS_KEEP_BIT];
					d.pcnt = '0;
					if (op_pay) begin
						d.pst = P_MOVE; // [RQ8] [RQ9] [RQ11]
					end else if (op_rdv) begin
						d.pst = P_RDV; // [RQ10]
					end else begin
						d.pst = P_DONE; // [RQ6] [RQ12]
					end
				end
			end
			P_MOVE: begin
				if (PAY_VALID_I) begin
					// Byte writes: any buffer alignment, no cache traffic
					if ((q.pop != isp_pkg::OP_FLUSH) &&
						(q.pcnt < q.desc[q.pidx][isp_pkg::W_LEN])) begin // [RQ9] [RQ17]
						d.mem_we = 1'b1; // [RQ15]
						d.mem_adr = q.desc[q.pidx][isp_pkg::W_BUF] + q.pcnt; // [RQ14]
						d.mem_dat = PAY_DATA_I;
					end
					d.pcnt = q.pcnt + 32'h1;
					if (PAY_LAST_I) begin
						// Rendezvous words read only for rendezvous codes
						d.pst = (q.pop == isp_pkg::OP_MOVE_RDV) ? P_RDV : P_DONE; // [RQ20]
					end
				end
			end
			P_RDV: begin
				d.rdv_valid = 1'b1; // [RQ10] [RQ11]
				d.rdv_ctx = {q.desc[q.pidx][isp_pkg::W_RDV1],
					q.desc[q.pidx][isp_pkg::W_RDV0]}; // [RQ19]
				if (q.rdv_valid && RDV_READY_I) begin
					d.rdv_valid = 1'b0;
					d.pst = P_DONE;
				end
			end
			P_DONE: begin
				free_push = !q.pkeep; // [RQ5] [RQ6]
				d.pst = P_IDLE;
			end
			default: d.pst = P_IDLE;
		endcase

		d.hdr_ready = (d.hst == H_BODY);
		d.pay_ready = (d.pst == P_MOVE);
		d.busy = (d.pst != P_IDLE);
	end

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lnk.ack = q.ack;
	assign lnk.rdat = q.rdat;
	assign HDR_READY_O = q.hdr_ready;
	assign PAY_READY_O = q.pay_ready;
	assign MEM_WE_O = q.mem_we;
	assign MEM_ADR_O = q.mem_adr;
	assign MEM_DAT_O = q.mem_dat;
	assign RDV_VALID_O = q.rdv_valid;
	assign RDV_CTX_O = q.rdv_ctx;
	assign BUSY_O = q.busy;
endmodule

/* rtl/isp_ctl_end.sv */
// Controller end: Wishbone slave that forwards software access to the socket
`timescale 1ns/10ps
module isp_ctl_end (
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	isp_sock_if.ctl lnk,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [11:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O
);
	typedef enum logic {C_IDLE, C_WAIT} isp_cst_e;
	typedef struct packed {
		isp_cst_e st;
		logic req;
		logic we;
		logic [11:0] adr;
		logic [31:0] wdat;
		logic ack;
		logic [31:0] rdat;
		logic last_empty;
		logic [7:0] ins_cnt;
	} isp_ctl_s;
	isp_ctl_s q;
	isp_ctl_s d;
	logic [31:0] stat;

	always_comb begin
		stat = '0;
		stat[isp_pkg::STAT_EMPTY_BIT] = q.last_empty;
		stat[isp_pkg::STAT_CNT_LSB +: 8] = q.ins_cnt;
	end

	always_comb begin
		d = q;
		d.ack = 1'b0;
		case (q.st)
			C_IDLE: begin
				// Ack just given blocks a second take of the same cycle
				if (WB_CYC_I && WB_STB_I && !q.ack) begin
					if (WB_ADR_I == isp_pkg::OFS_CTL_STAT) begin
						d.ack = 1'b1;
						d.rdat = WB_WE_I ? 32'h0 : stat;
					end else begin
						// Instructions pass unchanged, one per written word
						d.req = 1'b1; // [RQ4] [RQ7]
						d.we = WB_WE_I;
						d.adr = WB_ADR_I;
						d.wdat = WB_DAT_I;
						d.st = C_WAIT;
					end
				end
			end
			C_WAIT: begin
				if (lnk.ack) begin
					d.req = 1'b0;
					d.ack = 1'b1;
					d.rdat = q.we ? 32'h0 : lnk.rdat;
					d.st = C_IDLE;
					if (q.we && q.adr == isp_pkg::OFS_INSTR) begin
						d.ins_cnt = q.ins_cnt + 8'h1;
					end
					if (!q.we && q.adr == isp_pkg::OFS_PEND) begin
						d.last_empty = lnk.rdat[isp_pkg::ENT_EMPTY_BIT];
					end
				end
			end
			default: d.st = C_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lnk.req = q.req;
	assign lnk.we = q.we;
	assign lnk.adr = q.adr;
	assign lnk.wdat = q.wdat;
	assign WB_DAT_O = q.rdat;
	assign WB_ACK_O = q.ack;
endmodule

/* test/isp_chk.sv */
// Link checker between the socket end and its controller end
`timescale 1ns/10ps
module isp_chk #(
	parameter int DESC_NUM = 8
) (
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	input wire logic req,
	input wire logic we,
	input wire logic [11:0] adr,
	input wire logic [31:0] wdat,
	input wire logic [31:0] rdat,
	input wire logic ack
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!ARST_N_I);

	// ==========================================================
	// Handshake
	ack_one_cycle_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_latency_a: assert property (req && !ack |=> ack)
		else $error("link access stalled");
	ack_needs_req_a: assert property (ack |-> req)
		else $error("ack without request");
	req_steady_a: assert property (req && !ack |=> $stable({we, adr, wdat}))
		else $error("request changed before ack");
	req_release_a: assert property (ack |=> !req)
		else $error("request not released after ack");

	// ==========================================================
	// Read data
	empty_entry_a: assert property (ack && !we && adr == isp_pkg::OFS_PEND && rdat[0]
		|-> rdat == isp_pkg::ENT_EMPTY_VAL) else $error("bad empty entry");
	entry_fields_a: assert property (ack && !we && adr == isp_pkg::OFS_PEND && !rdat[0]
		|-> rdat[7:2] == 6'h00 && rdat[31:8] < DESC_NUM) else $error("bad entry fields");
	reserved_read_a: assert property (ack && !we && adr inside {12'h010, 12'h014, 12'h018}
		|-> rdat == 32'h0000_0000) else $error("reserved offset not zero");
endmodule

/* test/inbound_socket_transfer_engine_tb.sv */
// Self-checking bench for both socket ends joined by their link
`timescale 1ns/10ps
module inbound_socket_transfer_engine_tb;
	logic clk, rst_n, cyc, stb, wwe, hv, hl, hp, pv, pl, rr, wack, hrdy, prdy, mwe, rv, busy;
	logic [11:0] wadr, b;
	logic [31:0] wd, wdo, hd, madr, r2, r3, e, x, row;
	logic [7:0] pd, mdat;
	logic [63:0] ctx;
	int n_fail, n_checks, nw, nr;
	logic [31:0] rows [10] = '{32'h03050312, 32'h04040412, 32'h00040012, 32'h00030011,
		32'h02020a16, 32'h00000004, 32'h00000000, 32'h00000003, 32'h00000005, 32'h00000007};

	isp_sock_if lnk();
	isp_sock_end #(.DESC_NUM(4)) u_isp_sock_end (.REF_CLK_I(clk), .ARST_N_I(rst_n), .lnk(lnk),
		.HDR_VALID_I(hv), .HDR_DATA_I(hd), .HDR_LAST_I(hl), .HDR_HAS_PAY_I(hp),
		.HDR_READY_O(hrdy), .PAY_VALID_I(pv), .PAY_DATA_I(pd), .PAY_LAST_I(pl),
		.PAY_READY_O(prdy), .MEM_WE_O(mwe), .MEM_ADR_O(madr), .MEM_DAT_O(mdat),
		.RDV_VALID_O(rv), .RDV_CTX_O(ctx), .RDV_READY_I(rr), .BUSY_O(busy));
	isp_ctl_end u_isp_ctl_end (.REF_CLK_I(clk), .ARST_N_I(rst_n), .lnk(lnk), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(wwe), .WB_ADR_I(wadr), .WB_SEL_I(4'hf), .WB_DAT_I(wd),
		.WB_DAT_O(wdo), .WB_ACK_O(wack));
	isp_chk #(.DESC_NUM(4)) u_isp_chk (.REF_CLK_I(clk), .ARST_N_I(rst_n), .req(lnk.req),
		.we(lnk.we), .adr(lnk.adr), .wdat(lnk.wdat), .rdat(lnk.rdat), .ack(lnk.ack));

	// ==========================================================
	// Shared tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int t;
		cyc <= 1'b1;
		stb <= 1'b1;
		wwe <= w;
		wadr <= a;
		wd <= d;
		t = 0;
		do begin @(posedge clk); t++; end while (wack !== 1'b1 && t < 100);
		if (t >= 100) chk(32'h0, 32'h1);
		r = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		wwe <= 1'b0;
		@(posedge clk);
	endtask

	// Two header words; payload flag goes with the last one
	task frame(input logic [31:0] h0, input logic f);
		int t;
		hv <= 1'b1;
		hp <= f;
		for (int i = 0; i < 2; i++) begin
			hd <= h0 + i;
			hl <= (i == 1);
			t = 0;
			do begin @(posedge clk); t++; end while (hrdy !== 1'b1 && t < 400);
			if (t >= 400) chk(32'h0, 32'h1);
		end
		hv <= 1'b0;
		hl <= 1'b0;
		// Let an edge pass so a following frame never re-raises valid in this step
		@(posedge clk);
	endtask

	task pay(input int n);
		int t;
		pv <= 1'b1;
		for (int k = 0; k < n; k++) begin
			pd <= 8'ha0 + k[7:0];
			pl <= (k == n - 1);
			t = 0;
			do begin @(posedge clk); t++; end while (prdy !== 1'b1 && t < 100);
			if (t >= 100) chk(32'h0, 32'h1);
		end
		pv <= 1'b0;
		pl <= 1'b0;
	endtask

	task idle;
		int t;
		repeat (4) @(posedge clk);
		t = 0;
		while (busy !== 1'b0 && t < 300) begin @(posedge clk); t++; end
		if (busy !== 1'b0) chk(32'h0, 32'h1);
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Far-side observers; rendezvous channel stalls one cycle
	always @(posedge clk) begin
		if (mwe === 1'b1) begin
			chk(madr, 32'h0000_1003 + nw);
			chk({24'h0, mdat}, 32'ha0 + nw);
			nw++;
		end
		if (rv === 1'b1 && rr === 1'b1) begin
			chk(ctx[31:0], r2);
			chk(ctx[63:32], r3);
			nr++;
		end
		rr <= rv && !rr;
	end

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		summarize;
	end

	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, cyc, stb, wwe, hv, hl, hp, pv, pl} = '0;
		{wadr, wd, hd, pd} = '0;
		n_fail = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, isp_pkg::OFS_PEND, 32'h0, e);
		chk(e, isp_pkg::ENT_EMPTY_VAL);
		wb(1'b0, 12'h010, 32'h0, e);
		chk(e, 32'h0);
		for (int i = 0; i < 4; i++) wb(1'b1, isp_pkg::OFS_INSTR, i << 8, x);
		$display("reset and fill done");
		foreach (rows[r]) begin
			row = rows[r];
			frame(32'hc0de_0000 + r * 16, row[4]);
			wb(1'b0, isp_pkg::OFS_PEND, 32'h0, e);
			chk(e[1:0], {row[4], 1'b0});
			b = isp_pkg::OFS_DESC_BASE + {e[9:8], 5'h00};
			wb(1'b0, b + 12'h010, 32'h0, x);
			chk(x, 32'hc0de_0000 + r * 16);
			r2 = 32'h5a5a_0000 + r;
			r3 = 32'h3c3c_0000 + r;
			wb(1'b1, b, 32'h0000_1003, x);
			wb(1'b1, b + 12'h004, {24'h0, row[15:8]}, x);
			wb(1'b1, b + 12'h008, r2, x);
			wb(1'b1, b + 12'h00c, r3, x);
			nw = 0;
			nr = 0;
			wb(1'b1, isp_pkg::OFS_INSTR, {16'h0, e[15:8], 5'h00, row[2:0]}, x);
			if (row[4]) pay(row[23:16]);
			idle;
			chk(nw, {24'h0, row[31:24]});
			chk(nr, row[2:0] == 3'h4 || row[2:0] == 3'h6);
			$display("opcode row %0d done", r);
		end
		// Exhaust all descriptors, then return one kept and one freed
		for (int i = 0; i < 4; i++) frame(i, 1'b0);
		fork
			frame(32'h77, 1'b0);
		join_none
		repeat (30) @(posedge clk);
		chk(hrdy, 1'b0);
		wb(1'b0, isp_pkg::OFS_PEND, 32'h0, e);
		wb(1'b1, isp_pkg::OFS_INSTR, {16'h0, e[15:8], 8'h08}, x);
		repeat (30) @(posedge clk);
		chk(hrdy, 1'b0);
		wb(1'b0, isp_pkg::OFS_PEND, 32'h0, e);
		wb(1'b1, isp_pkg::OFS_INSTR, {16'h0, e[15:8], 8'h00}, x);
		wait fork;
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, isp_pkg::OFS_PEND, 32'h0, e);
			chk(e[0], i == 3);
		end
		// Sixteen instructions sent so far; last pending read found the list empty
		wb(1'b0, isp_pkg::OFS_CTL_STAT, 32'h0, e);
		chk(e, (32'h10 << isp_pkg::STAT_CNT_LSB) | (32'h1 << isp_pkg::STAT_EMPTY_BIT));
		$display("stall test done");
		// ==========================================================
		// Reset in mid-run: outputs low, controller status and lists cleared
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({26'h0, hrdy, prdy, mwe, rv, busy, wack}, 32'h0);
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, isp_pkg::OFS_CTL_STAT, 32'h0, e);
		chk(e, 32'h0);
		wb(1'b0, isp_pkg::OFS_PEND, 32'h0, e);
		chk(e, isp_pkg::ENT_EMPTY_VAL);
		$display("mid-run reset done");
		summarize;
	end
endmodule
